// >>> rtl/rcs_pkg.sv
// rcs_pkg: constants, states and state layout of the reset cause block
// assumes a 25 MHz core clock and a 32-bit classic wishbone register port
package rcs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 40;
  localparam int PWRT_TIME_MS     = 72;
  localparam int PWRT_CYCLES_DFLT = (PWRT_TIME_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_CYCLES       = 1024;  // oscillator periods, counted on clk
  localparam int SYNC_WAIT        = 3;     // cycles before synced straps are trusted
  localparam int CNT_W            = 22;
  localparam int WORD_W           = 14;
  localparam int PC_W             = 13;
  localparam int CFG_W            = 5;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_PSR   = 8'h00;  // power_status_reg
  localparam logic [7:0] ADR_FLAGS = 8'h04;  // core flags and decoded cause
  localparam logic [7:0] ADR_CFG   = 8'h08;  // synced configuration straps
  localparam logic [7:0] ADR_PC    = 8'h0C;  // last restart address
  localparam int PSR_BOR   = 0;
  localparam int PSR_POR   = 1;
  localparam int PSR_PAR   = 2;
  localparam int PSR_MIR   = 7;
  localparam int FLG_SLEEP = 0;
  localparam int FLG_WDOG  = 1;
  localparam int FLG_CAUSE = 4;
  localparam int FLG_HOLD  = 7;
  localparam int CFG_OSC   = 0;  // two bits
  localparam int CFG_DLY   = 2;
  localparam int CFG_DET   = 3;
  localparam int CFG_PAR   = 4;

  // ----------------------------------------------------------------
  // oscillator modes, addresses, status loads {val[7:3], mask[7:3]}
  // ----------------------------------------------------------------
  localparam logic [1:0] LOW_POWER_CRYSTAL_MODE      = 2'h0;
  localparam logic [1:0] STANDARD_CRYSTAL_MODE       = 2'h1;
  localparam logic [1:0] HIGH_SPEED_CRYSTAL_MODE     = 2'h2;
  localparam logic [1:0] RESISTOR_CAPACITOR_OSC_MODE = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC  = 13'h0004;
  localparam logic [9:0] STAT_POWER_UP   = 10'h07F;
  localparam logic [9:0] STAT_RUN_CLEAR  = 10'h01C;
  localparam logic [9:0] STAT_SLEEP_CLR  = 10'h05F;
  localparam logic [9:0] STAT_WDOG_RESET = 10'h03F;
  localparam logic [9:0] STAT_WDOG_WAKE  = 10'h003;
  localparam logic [9:0] STAT_DROP       = 10'h07F;
  localparam logic [9:0] STAT_PARITY     = 10'h063;
  localparam logic [9:0] STAT_SLEEP_IRQ  = 10'h043;
  localparam logic [2:0] CAUSE_POWER_UP  = 3'h0;
  localparam logic [2:0] CAUSE_DROP      = 3'h1;
  localparam logic [2:0] CAUSE_PARITY    = 3'h2;
  localparam logic [2:0] CAUSE_WDOG_RST  = 3'h3;
  localparam logic [2:0] CAUSE_WDOG_WAKE = 3'h4;
  localparam logic [2:0] CAUSE_SLEEP_IRQ = 3'h5;
  localparam logic [2:0] CAUSE_RUN_CLEAR = 3'h6;

  // ----------------------------------------------------------------
  // sequencer states and the whole state of the block
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_START, ST_POWER_WAIT, ST_OSC_WAIT, ST_HELD, ST_RUN, ST_SLEEP
  } rcs_state_e;

  typedef struct packed {
    rcs_state_e             state;
    logic [CNT_W-1:0]       cnt;
    logic                   m1, m2, d1, d2;
    logic [CFG_W-1:0]       c1, c2;
    logic                   bor, por, par, wdt_f, slp_f;
    logic                   hold, pc_ld, stat_ld, ack;
    logic [PC_W-1:0]        pc;
    logic [9:0]             stat;
    logic [31:0]            rdat;
  } rcs_state_s;

  localparam rcs_state_s RST_VAL = '{state: ST_START, cnt: '0, m1: 1'b1, m2: 1'b1,
                                     d1: 1'b0, d2: 1'b0, c1: '0, c2: '0, bor: 1'b0,
                                     por: 1'b0, par: 1'b1, wdt_f: 1'b1, slp_f: 1'b1,
                                     hold: 1'b1, pc_ld: 1'b0, stat_ld: 1'b0, ack: 1'b0,
                                     pc: '0, stat: '0, rdat: '0};

endpackage

// >>> rtl/rcs_parity_chk.sv
// rcs_parity_chk: two-bit parity check of one fetched program word
// assumes word and parity bits are stable in the cycle they are judged
`timescale 1ns/10ps
`default_nettype none
module rcs_parity_chk #(
  parameter int WORD_W = 14
) (
  // fetched word and its parity pair
  input  wire logic [WORD_W-1:0] word,
  input  wire logic              even_par,
  input  wire logic              odd_par,
  // verdict
  output logic                   fault
);

  if (WORD_W < 2) begin : g_bad_width
    $error("rcs_parity_chk: word must hold at least two bits");
  end

  // ----------------------------------------------------------------
  // even bits against the even-parity bit, odd bits against the inverted odd one
  // ----------------------------------------------------------------
  always_comb begin : check
    logic ev;
    logic od;
    ev = even_par;
    od = ~odd_par;
    for (int i = 0; i < WORD_W; i++) begin
      if (i % 2 == 0) begin
        ev = ev ^ word[i];
      end else begin
        od = od ^ word[i];
      end
    end
    fault = ev | od;  // nonzero result marks a fault
  end

endmodule  // rcs_parity_chk
`default_nettype wire

// >>> rtl/rcs_reset_cause.sv
// rcs_reset_cause: reset cause flags, start-up hold and restart values
// assumes core events are on clk; pins and straps arrive unsynchronised
//
// Functional notes
// - supply-drop flag low after drop, else software value
// - drop detection off: drop flag meaningless, untouched
// - power-up flag cleared only by power-up
// - parity flag cleared by parity reset, set by power-up
// - status bit 7 mirrors parity enable strap
// - each word carries even and odd parity bits
// - check each fetch; nonzero xor is a fault
// - parity fault resets and clears parity flag
// - parity strap zero disables checking, one enables
// - power-up hold: 72 ms and/or 1024 periods per mode
// - drop hold 72 ms plus crystal wait; crystal wake waits 1024
// - watchdog and sleep flags encode the reset cause
// - power-up and drop causes decoded from power flags
// - parity cause decoded; power-up and drop set flag
// - resets restart at 000h; wake at pc+1 or 0004h
// - core status bits loaded per reset cause
// - parity variant power status values per cause
// - two-bit variant power status values per cause
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rcs_reset_cause
  import rcs_pkg::*;
#(
  parameter int PWRT_CYCLES     = rcs_pkg::PWRT_CYCLES_DFLT,
  parameter bit PARITY_VARIANT  = 1'b1,
  parameter bit HAS_SUPPLY_DROP = 1'b1,
  parameter bit DLY_EN_LEVEL    = 1'b0  // strap level that turns the delay on
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // wishbone slave
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic                     wb_we_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  // pins and configuration straps
  input  wire logic                     master_clear_pin_n,
  input  wire logic                     supply_drop_det,
  input  wire logic [rcs_pkg::CFG_W-1:0] config_straps,
  // core events
  input  wire logic                     watchdog_expired,
  input  wire logic                     sleep_cmd,
  input  wire logic                     irq_wake,
  input  wire logic                     global_irq_enable,
  input  wire logic [rcs_pkg::PC_W-1:0] pc_now,
  // program fetch
  input  wire logic                     fetch_valid,
  input  wire logic [rcs_pkg::WORD_W-1:0] fetch_word,
  input  wire logic [1:0]               fetch_parity,
  // core controls
  output logic                          core_hold,
  output logic                          pc_load,
  output logic [rcs_pkg::PC_W-1:0]      pc_value,
  output logic                          status_load,
  output logic [4:0]                    status_val,
  output logic [4:0]                    status_mask
);

  if (PWRT_CYCLES < 1 || PWRT_CYCLES >= 2 ** CNT_W) begin : g_bad_pwrt
    $error("rcs_reset_cause: power wait count out of range");
  end

  // ----------------------------------------------------------------
  // state and derived terms
  // ----------------------------------------------------------------
  rcs_state_s st, n;
  logic       xtal, dly, det_on, drop, par_on, perr, perr_hit, master_clear_pin_low;
  logic       access, wr_psr;
  logic [2:0] cause;
  logic [31:0] rd_mux;
  logic [PC_W-1:0] pc_inc;

  localparam logic [CNT_W-1:0] PW_LAST   = CNT_W'(PWRT_CYCLES - 1);
  localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_CYCLES - 1);
  localparam logic [CNT_W-1:0] SYNC_LAST = CNT_W'(SYNC_WAIT - 1);

  // strap decode, read only from the second sync stage
  assign xtal     = st.c2[CFG_OSC +: 2] != RESISTOR_CAPACITOR_OSC_MODE;
  assign dly      = st.c2[CFG_DLY] == DLY_EN_LEVEL;
  assign det_on   = HAS_SUPPLY_DROP && st.c2[CFG_DET];
  assign drop     = det_on && st.d2 && st.state != ST_START;
  assign par_on   = PARITY_VARIANT && st.c2[CFG_PAR];
  assign master_clear_pin_low = !st.m2;
  assign pc_inc   = pc_now + 13'h0001;

  // fetch check
  rcs_parity_chk #(
    .WORD_W   (WORD_W)
  ) u_parity (
    .word     (fetch_word),
    .even_par (fetch_parity[0]),
    .odd_par  (fetch_parity[1]),
    .fault    (perr)
  );
  assign perr_hit = par_on && fetch_valid && perr && st.state == ST_RUN;

  // bus decode
  assign access = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr_psr = access && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == ADR_PSR[7:2];

  // ----------------------------------------------------------------
  // reset cause decode from the flags
  // ----------------------------------------------------------------
  always_comb begin : decode
    if (!st.por) begin
      cause = CAUSE_POWER_UP;
    end else if (HAS_SUPPLY_DROP && !st.bor) begin
      cause = CAUSE_DROP;
    end else if (PARITY_VARIANT && !st.par && st.wdt_f && st.slp_f) begin
      cause = CAUSE_PARITY;
    end else begin
      case ({st.wdt_f, st.slp_f})
        2'b01:   cause = CAUSE_WDOG_RST;
        2'b00:   cause = CAUSE_WDOG_WAKE;
        2'b10:   cause = CAUSE_SLEEP_IRQ;
        default: cause = CAUSE_RUN_CLEAR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin : read_mux
    rd_mux = '0;
    case (wb_adr_i[7:2])
      ADR_PSR[7:2]: begin
        rd_mux[PSR_BOR] = st.bor;
        rd_mux[PSR_POR] = st.por;
        rd_mux[PSR_PAR] = PARITY_VARIANT && st.par;
        rd_mux[PSR_MIR] = par_on;
      end
      ADR_FLAGS[7:2]: begin
        rd_mux[FLG_SLEEP]      = st.slp_f;
        rd_mux[FLG_WDOG]       = st.wdt_f;
        rd_mux[FLG_CAUSE +: 3] = cause;
        rd_mux[FLG_HOLD]       = st.hold;
      end
      ADR_CFG[7:2]: begin
        rd_mux[CFG_W-1:0] = st.c2;
      end
      ADR_PC[7:2]: begin
        rd_mux[PC_W-1:0] = st.pc;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin : next_state
    logic pw;
    logic ow;
    logic rel;
    pw = 1'b0;
    ow = 1'b0;
    rel = 1'b0;
    n = st;
    n.pc_ld = 1'b0;
    n.stat_ld = 1'b0;
    n.ack = 1'b0;
    // two-stage synchronisers
    n.m1 = master_clear_pin_n;
    n.m2 = st.m1;
    n.d1 = supply_drop_det;
    n.d2 = st.d1;
    n.c1 = config_straps;
    n.c2 = st.c1;
    // register access, answered one cycle after the request
    if (access) begin
      n.ack = 1'b1;
      n.rdat = rd_mux;
    end
    // software stores flag values; hardware events below win
    if (wr_psr) begin
      n.bor = wb_dat_i[PSR_BOR];
      n.por = wb_dat_i[PSR_POR];
      if (PARITY_VARIANT) begin
        n.par = wb_dat_i[PSR_PAR];
      end
    end
    case (st.state)
      ST_START: begin
        if (st.cnt == SYNC_LAST) begin
          n.stat = STAT_POWER_UP;
          n.stat_ld = 1'b1;
          n.pc = PC_RESET;
          pw = dly;
          ow = !dly;
        end else begin
          n.cnt = st.cnt + 1'b1;
        end
      end
      ST_POWER_WAIT: begin
        if (st.cnt == PW_LAST) begin
          ow = 1'b1;
        end else begin
          n.cnt = st.cnt + 1'b1;
        end
      end
      ST_OSC_WAIT: begin
        if (st.cnt == OST_LAST) begin
          rel = 1'b1;
        end else begin
          n.cnt = st.cnt + 1'b1;
        end
      end
      ST_HELD: begin
        rel = !master_clear_pin_low;
      end
      ST_RUN: begin
        if (perr_hit) begin
          n.par = 1'b0;
          n.wdt_f = 1'b1;
          n.slp_f = 1'b1;
          n.stat = STAT_PARITY;
          n.stat_ld = 1'b1;
          n.pc = PC_RESET;
          n.hold = 1'b1;
          n.state = ST_HELD;
        end else if (watchdog_expired) begin
          n.wdt_f = 1'b0;
          n.slp_f = 1'b1;
          n.stat = STAT_WDOG_RESET;
          n.stat_ld = 1'b1;
          n.pc = PC_RESET;
          n.hold = 1'b1;
          n.state = ST_HELD;
        end else if (master_clear_pin_low) begin
          n.stat = STAT_RUN_CLEAR;
          n.stat_ld = 1'b1;
          n.pc = PC_RESET;
          n.hold = 1'b1;
          n.state = ST_HELD;
        end else if (sleep_cmd) begin
          n.wdt_f = 1'b1;
          n.slp_f = 1'b0;
          n.stat = STAT_SLEEP_IRQ;
          n.stat_ld = 1'b1;
          n.state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (master_clear_pin_low) begin
          n.wdt_f = 1'b1;
          n.slp_f = 1'b0;
          n.stat = STAT_SLEEP_CLR;
          n.stat_ld = 1'b1;
          n.pc = PC_RESET;
          n.hold = 1'b1;
          n.state = ST_HELD;
        end else if (watchdog_expired) begin
          n.wdt_f = 1'b0;
          n.slp_f = 1'b0;
          n.stat = STAT_WDOG_WAKE;
          n.stat_ld = 1'b1;
          n.pc = pc_inc;
          ow = 1'b1;
        end else if (irq_wake) begin
          n.stat = STAT_SLEEP_IRQ;
          n.stat_ld = 1'b1;
          n.pc = global_irq_enable ? IRQ_VEC : pc_inc;
          ow = 1'b1;
        end
      end
      default: begin
        n.state = ST_START;
        n.hold = 1'b1;
      end
    endcase
    // timed holds and release
    if (pw) begin
      n.state = ST_POWER_WAIT;
      n.cnt = '0;
      n.hold = 1'b1;
    end else if (ow && xtal) begin
      n.state = ST_OSC_WAIT;
      n.cnt = '0;
      n.hold = 1'b1;
    end else if (ow || rel) begin
      if (master_clear_pin_low) begin
        n.state = ST_HELD;
        n.hold = 1'b1;
      end else begin
        n.state = ST_RUN;
        n.hold = 1'b0;
        n.pc_ld = 1'b1;
      end
    end
    // supply drop overrides everything except a same-cycle por write, bus answer or pc_ld pulse and restarts the power wait
    if (drop) begin
      n.bor = 1'b0;
      if (PARITY_VARIANT) begin
        n.par = 1'b1;
      end
      n.wdt_f = 1'b1;
      n.slp_f = 1'b1;
      n.stat = STAT_DROP;
      n.stat_ld = 1'b1;
      n.pc = PC_RESET;
      n.state = ST_POWER_WAIT;
      n.cnt = '0;
      n.hold = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin : regs
    if (sys_rst) begin
      st <= RST_VAL;  // power-up values
    end else begin
      st <= n;
    end
  end

  // outputs straight from the state register
  assign core_hold   = st.hold;
  assign pc_load     = st.pc_ld;
  assign pc_value    = st.pc;
  assign status_load = st.stat_ld;
  assign status_val  = st.stat[9:5];
  assign status_mask = st.stat[4:0];
  assign wb_ack_o    = st.ack;
  assign wb_dat_o    = st.rdat;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_osc_done;
    st.state == ST_OSC_WAIT && st.cnt == OST_LAST && !master_clear_pin_low && !drop;
  endsequence

  sequence s_power_done;
    st.state == ST_POWER_WAIT && st.cnt == PW_LAST && !drop;
  endsequence

  a_parity_trip: assert property (perr_hit && !drop |=>
    !st.par && st.hold && st.stat == STAT_PARITY && st.pc == PC_RESET)
    else $error("parity fault did not reset");

  a_drop_hold: assert property (drop |=>
    !st.bor && st.hold && st.state == ST_POWER_WAIT && st.cnt == '0)
    else $error("supply drop not held");

  a_drop_ignored: assert property (!det_on && !wr_psr |=> $stable(st.bor))
    else $error("drop flag moved with detection off");

  a_power_to_osc: assert property (s_power_done ##0 xtal |=>
    st.state == ST_OSC_WAIT && st.cnt == '0 && st.hold)
    else $error("crystal wait did not follow power wait");

  a_osc_release: assert property (s_osc_done |=> !st.hold && st.pc_ld ##1 !st.pc_ld)
    else $error("release after crystal wait wrong");

  a_wdog_reset: assert property (st.state == ST_RUN && watchdog_expired && !perr_hit && !drop |=>
    !st.wdt_f && st.slp_f && st.pc == PC_RESET && st.stat == STAT_WDOG_RESET)
    else $error("watchdog reset flags wrong");

  a_irq_vector: assert property (st.state == ST_SLEEP && !master_clear_pin_low && !watchdog_expired
    && irq_wake && global_irq_enable && !drop |=> st.pc == IRQ_VEC)
    else $error("interrupt wake vector wrong");

  a_mirror_read: assert property (access && !wb_we_i && wb_adr_i[7:2] == ADR_PSR[7:2]
    |=> st.ack && st.rdat[PSR_MIR] == $past(par_on))
    else $error("mirror bit read wrong");

  a_flag_write: assert property (wr_psr && !drop && st.state != ST_START
    |=> st.bor == $past(wb_dat_i[PSR_BOR]) && st.por == $past(wb_dat_i[PSR_POR]))
    else $error("flag write not stored");

  a_power_flag: assert property (st.por && !wr_psr |=> st.por)
    else $error("power-up flag cleared without power-up");

endmodule  // rcs_reset_cause
`default_nettype wire

// >>> dv/tb_rcs_reset_cause.sv
// tb_rcs_reset_cause: self-checking bench of the reset cause block
// assumes a one-cycle register answer and a shortened power-up delay
`timescale 1ns/10ps
`default_nettype none
module tb_rcs_reset_cause;
  import rcs_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam int PWRT = 20;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [3:0]  wb_sel_i = 4'h1;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_ack_o;
  logic        master_clear_pin_n = 1'b1;
  logic        supply_drop_det = 1'b0;
  logic [4:0]  config_straps = 5'h1B;  // parity on, drop on, delay on, rc
  logic        watchdog_expired = 1'b0;
  logic        sleep_cmd = 1'b0;
  logic        irq_wake = 1'b0;
  logic        global_irq_enable = 1'b1;
  logic [12:0] pc_now = 13'h0123;
  logic        fetch_valid = 1'b0;
  logic [13:0] fetch_word = 14'h0003;
  logic [1:0]  fetch_parity = 2'h1;    // clean pair for this word
  logic        core_hold, pc_load, status_load;
  logic [12:0] pc_value;
  logic [4:0]  status_val, status_mask;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          hold_n;

  rcs_reset_cause #(.PWRT_CYCLES(PWRT)) DUT (
    .clk(clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .master_clear_pin_n(master_clear_pin_n),
    .supply_drop_det(supply_drop_det), .config_straps(config_straps),
    .watchdog_expired(watchdog_expired), .sleep_cmd(sleep_cmd), .irq_wake(irq_wake),
    .global_irq_enable(global_irq_enable), .pc_now(pc_now), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_parity(fetch_parity), .core_hold(core_hold),
    .pc_load(pc_load), .pc_value(pc_value), .status_load(status_load),
    .status_val(status_val), .status_mask(status_mask));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= 32'(dat);
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    check(what, rd, 32'(exp));
  endtask

  // poll for the status load; a zero mask skips the field compare
  task automatic wait_status(input logic [4:0] v, input logic [4:0] m);
    int n;
    n = 0;
    while (status_load !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("status load", 32'(status_load), 32'h0000_0001);
    if (m != 5'h00) begin
      check("status mask", 32'(status_mask), 32'(m));
      check("status bits", 32'(status_val & m), 32'(v));
    end
  endtask

  // count held cycles, then expect the restart pulse
  task automatic wait_run(input logic [12:0] pc_exp);
    hold_n = 0;
    while (core_hold !== 1'b0 && hold_n < 2000) begin
      @(posedge clk);
      #1;
      hold_n++;
    end
    check("restart pulse", 32'(pc_load), 32'h0000_0001);
    check("restart pc", 32'(pc_value), 32'(pc_exp));
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1 wait_status(5'h03, 5'h1f);
    wait_run(13'h0000);
    check("power-up hold", 32'(hold_n >= PWRT && hold_n <= PWRT + 2), 32'h0000_0001);
    rdchk("psr after power-up", ADR_PSR, 8'h84);
    rdchk("cause power-up", ADR_FLAGS, 8'h03);
    bus(1'b1, ADR_PSR, 8'hff);
    rdchk("psr after write", ADR_PSR, 8'h87);
    rdchk("unmapped read", 8'h30, 8'h00);
    $display("test power-up done");
    // clean fetch must not reset, flipped odd bit must
    @(posedge clk) fetch_valid <= 1'b1;
    @(posedge clk) fetch_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check("hold after clean fetch", 32'(core_hold), 32'h0000_0000);
    @(posedge clk) fetch_valid <= 1'b1;
    fetch_parity <= 2'h3;
    @(posedge clk) fetch_valid <= 1'b0;
    fetch_parity <= 2'h1;
    #1 wait_status(5'h03, 5'h03);
    wait_run(13'h0000);
    rdchk("psr after parity", ADR_PSR, 8'h83);
    rdchk("cause parity", ADR_FLAGS, 8'h23);
    bus(1'b1, ADR_PSR, 8'h07);
    $display("test parity done");
    @(posedge clk) watchdog_expired <= 1'b1;
    @(posedge clk) watchdog_expired <= 1'b0;
    #1 wait_status(5'h01, 5'h1f);
    wait_run(13'h0000);
    rdchk("psr after watchdog", ADR_PSR, 8'h87);
    rdchk("cause watchdog", ADR_FLAGS, 8'h31);
    $display("test watchdog reset done");
    @(posedge clk) supply_drop_det <= 1'b1;
    #1 wait_status(5'h03, 5'h1f);
    @(posedge clk) supply_drop_det <= 1'b0;
    #1 wait_run(13'h0000);
    check("drop hold", 32'(hold_n >= PWRT && hold_n <= PWRT + 6), 32'h0000_0001);
    rdchk("psr after drop", ADR_PSR, 8'h86);
    rdchk("cause drop", ADR_FLAGS, 8'h13);
    bus(1'b1, ADR_PSR, 8'h07);
    $display("test supply drop done");
    @(posedge clk) master_clear_pin_n <= 1'b0;
    #1 wait_status(5'h00, 5'h1c);
    @(posedge clk) master_clear_pin_n <= 1'b1;
    #1 wait_run(13'h0000);
    rdchk("psr after clear", ADR_PSR, 8'h87);
    rdchk("cause run clear", ADR_FLAGS, 8'h63);
    $display("test master clear done");
    @(posedge clk) sleep_cmd <= 1'b1;
    @(posedge clk) sleep_cmd <= 1'b0;
    #1 wait_status(5'h02, 5'h03);
    @(posedge clk) watchdog_expired <= 1'b1;
    @(posedge clk) watchdog_expired <= 1'b0;
    #1 wait_status(5'h00, 5'h03);
    check("watchdog wake pc", 32'(pc_value), 32'h0000_0124);
    check("rc wake no hold", 32'(core_hold), 32'h0000_0000);
    rdchk("cause watchdog wake", ADR_FLAGS, 8'h40);
    @(posedge clk) sleep_cmd <= 1'b1;
    @(posedge clk) sleep_cmd <= 1'b0;
    #1 wait_status(5'h02, 5'h03);
    @(posedge clk) irq_wake <= 1'b1;
    @(posedge clk) irq_wake <= 1'b0;
    #1 wait_status(5'h02, 5'h03);
    check("irq wake pc", 32'(pc_value), 32'h0000_0004);
    rdchk("restart pc reg", ADR_PC, 8'h04);
    rdchk("cause irq wake", ADR_FLAGS, 8'h52);
    rdchk("psr after wakes", ADR_PSR, 8'h87);
    $display("test sleep wake done");
    // parity strap cleared: bad words pass, mirror follows
    @(posedge clk) config_straps <= 5'h0B;
    repeat (5) @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_parity <= 2'h3;
    @(posedge clk) fetch_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check("hold with parity off", 32'(core_hold), 32'h0000_0000);
    rdchk("psr parity off", ADR_PSR, 8'h07);
    rdchk("synced straps", ADR_CFG, 8'h0b);
    $display("test parity disable done");
    // crystal mode: wake and drop both wait out the oscillator count
    @(posedge clk) config_straps <= 5'h09;
    global_irq_enable <= 1'b0;
    repeat (4) @(posedge clk);
    sleep_cmd <= 1'b1;
    @(posedge clk) sleep_cmd <= 1'b0;
    #1 wait_status(5'h02, 5'h03);
    @(posedge clk) irq_wake <= 1'b1;
    @(posedge clk) irq_wake <= 1'b0;
    #1 wait_status(5'h02, 5'h03);
    wait_run(13'h0124);
    check("crystal wake hold",
          32'(hold_n >= OST_CYCLES && hold_n <= OST_CYCLES + 2), 32'h0000_0001);
    @(posedge clk) supply_drop_det <= 1'b1;
    #1 wait_status(5'h03, 5'h1f);
    @(posedge clk) supply_drop_det <= 1'b0;
    #1 wait_run(13'h0000);
    check("crystal drop hold",
          32'(hold_n >= PWRT + OST_CYCLES && hold_n <= PWRT + OST_CYCLES + 6), 32'h0000_0001);
    $display("test crystal waits done");
    final_report();
  end
endmodule // tb_rcs_reset_cause
`default_nettype wire
